// File: hw/scid_top.sv
// Servo command input decoder top: PWM, step and analog command paths
// Contract
// - PWM duty drives current command in current mode, velocity in velocity mode.
// - One-wire: half duty gives zero, above positive, below negative, proportionally.
// - One-wire invert option negates the command.
// - Two-wire: magnitude linear from zero to full scale, sign from polarity.
// - Two-wire invert maps rising duty to falling magnitude.
// - Stuck protection turns a constant low or high input into zero.
// - Position mode takes two step inputs in a selectable format.
// - Every step format has a sign reversal option.
// - Pulse/direction: each pulse is one step, signed by direction level.
// - Counting edge selectable rising or falling for pulse and up/down.
// - Up/down: first input adds a step, second subtracts one.
// - Quadrature: motion and direction from A/B phase relation.
// - Decoded steps are multiplied by the gearing ratio.
// - Zero acceleration limit bypasses smoothing for analog or step sources.
// - Zero acceleration limit inhibits motion for network, serial, program sources.
// - Samples within dead band give zero; others lose band width, keep sign.
// - Analog command equals sample times programmable scale factor.
// - Signed offset is added to each sample before conditioning.
// - Measure averages ten samples spread over about 200 ms.
// - Monitored analog value is after offset and dead band.
// - Analog position latches input at enable, moves by later changes.
`timescale 1ns/1ps
`include "scid_map.svh"
module scid_top
    import scid_pkg::*;
#(
    parameter int MEAS_GAP_CYC = `SCID_MEAS_GAP_CYC,
    parameter int STUCK_CYC = `SCID_STUCK_CYC
) (
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    input wire logic PWM_IN_PIN,
    input wire logic PWM_DIR_PIN,
    input wire logic STEP_A_PIN,
    input wire logic STEP_B_PIN,
    input scid_mode_t CTRL_MODE,
    input scid_src_t CMD_SRC,
    input wire logic PWM_TWO_WIRE,
    input wire logic PWM_INVERT,
    input wire logic PWM_STUCK_PROT,
    input scid_fmt_t STEP_FMT,
    input wire logic STEP_FALL_EDGE,
    input wire logic STEP_INVERT,
    input wire logic [15:0] GEAR_RATIO,
    input wire logic [15:0] ACCEL_LIMIT,
    input wire logic DRIVE_EN,
    input wire logic signed [15:0] ANA_SAMPLE,
    input wire logic ANA_VALID,
    input wire logic signed [15:0] ANA_OFFSET,
    input wire logic [15:0] ANA_DEADBAND,
    input wire logic [15:0] ANA_SCALE,
    input wire logic MEAS_START,
    output logic signed [15:0] CUR_CMD,
    output logic signed [15:0] VEL_CMD,
    output logic signed [31:0] POS_CMD,
    output logic signed [15:0] ANA_MON,
    output logic signed [15:0] MEAS_AVG,
    output logic MEAS_BUSY,
    output logic MEAS_DONE,
    output logic TRAJ_BYPASS,
    output logic MOTION_INHIBIT
);
    function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
        if (v > `SCID_CMD_MAX) begin
            return 16'sh7FFF;
        end else if (v < `SCID_CMD_MIN) begin
            return 16'sh8001;
        end
        return v[15:0];
    endfunction

    function automatic logic signed [31:0] scale_val(input logic signed [16:0] v, input logic [15:0] s);
        logic signed [33:0] p;
        p = v * $signed({1'b0, s});
        return 32'(p >>> `SCID_SCALE_FRAC);
    endfunction

    // Pin synchronisers: bit 0 PWM, 1 direction, 2 step A, 3 step B
    logic [3:0] sync1_reg, sync1_next, sync2_reg, sync2_next;

    always_comb begin
        sync1_next = {STEP_B_PIN, STEP_A_PIN, PWM_DIR_PIN, PWM_IN_PIN};
        sync2_next = sync1_reg;
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    logic [16:0] duty;
    logic duty_vld, stuck_hi, stuck_lo, step_up, step_dn;

    scid_pwm_meas #(.STUCK_CYC(STUCK_CYC)) u_pwm (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .pin(sync2_reg[0]),
        .duty(duty),
        .duty_vld(duty_vld),
        .stuck_hi(stuck_hi),
        .stuck_lo(stuck_lo)
    );

    scid_step_dec u_step (
        .clk(CORE_CLK),
        .arst_n(ARST_N),
        .a(sync2_reg[2]),
        .b(sync2_reg[3]),
        .fmt(STEP_FMT),
        .fall_sel(STEP_FALL_EDGE),
        .up(step_up),
        .dn(step_dn)
    );

    // PWM command from the latest measured duty
    logic [16:0] duty_eff, mag2;
    logic signed [31:0] pwm_raw;
    logic signed [15:0] pwm_cmd;

    always_comb begin
        // A stuck line has no periods to measure; take it as 0 or 100 percent
        duty_eff = stuck_hi ? `SCID_DUTY_FULL : (stuck_lo ? 17'h00000 : duty);
        mag2 = PWM_INVERT ? `SCID_DUTY_FULL - duty_eff : duty_eff;
        if (PWM_TWO_WIRE) begin
            pwm_raw = sync2_reg[1] ? -32'(mag2) : 32'(mag2);
        end else begin
            pwm_raw = 32'({duty_eff, 1'b0}) - 32'(`SCID_DUTY_FULL);
            pwm_raw = PWM_INVERT ? -pwm_raw : pwm_raw;
        end
        if (PWM_STUCK_PROT && (stuck_hi || stuck_lo)) begin
            pwm_raw = 32'sh00000000;
        end
        pwm_cmd = sat16(pwm_raw);
    end

    // Analog conditioning: offset, dead band, scale
    logic signed [31:0] ana_off32, ana_mag, ana_rem;
    logic signed [15:0] ana_sat, ana_db;
    logic signed [15:0] ana_mon_reg, ana_mon_next, ana_cmd_reg, ana_cmd_next, ana_last_reg, ana_last_next;

    always_comb begin
        ana_off32 = 32'(ANA_SAMPLE) + 32'(ANA_OFFSET);
        ana_sat = sat16(ana_off32);
        ana_mag = ana_sat[15] ? -32'(ana_sat) : 32'(ana_sat);
        ana_rem = ana_mag - 32'({16'h0000, ANA_DEADBAND});
        if (ana_rem <= 32'sh00000000) begin
            ana_db = 16'sh0000;
        end else begin
            ana_db = sat16(ana_sat[15] ? -ana_rem : ana_rem);
        end
        ana_mon_next = ANA_VALID ? ana_db : ana_mon_reg;
        ana_cmd_next = ANA_VALID ? sat16(scale_val(17'(ana_db), ANA_SCALE)) : ana_cmd_reg;
        ana_last_next = ANA_VALID ? ANA_SAMPLE : ana_last_reg;
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ana_mon_reg <= 16'sh0000;
            ana_cmd_reg <= 16'sh0000;
            ana_last_reg <= 16'sh0000;
        end else begin
            ana_mon_reg <= ana_mon_next;
            ana_cmd_reg <= ana_cmd_next;
            ana_last_reg <= ana_last_next;
        end
    end

    // Current, velocity, position commands and smoothing flags
    logic signed [15:0] cur_reg, cur_next, vel_reg, vel_next, src_cmd, base_reg, base_next;
    logic signed [31:0] pos_reg, pos_next, anchor_reg, anchor_next;
    logic en_q_reg, en_q_next, bypass_reg, bypass_next, inhibit_reg, inhibit_next;
    logic up_i, dn_i, accel_zero, src_local;

    always_comb begin
        case (CMD_SRC)
            SCID_SRC_PWM: src_cmd = pwm_cmd;
            SCID_SRC_ANA: src_cmd = ana_cmd_reg;
            default: src_cmd = 16'sh0000;
        endcase
        cur_next = (CTRL_MODE == SCID_CUR) ? src_cmd : 16'sh0000;
        vel_next = (CTRL_MODE == SCID_VEL) ? src_cmd : 16'sh0000;
        accel_zero = ACCEL_LIMIT == 16'h0000;
        src_local = CMD_SRC == SCID_SRC_ANA || CMD_SRC == SCID_SRC_PWM || CMD_SRC == SCID_SRC_STEP;
        bypass_next = accel_zero && src_local;
        inhibit_next = accel_zero && !src_local;
        up_i = STEP_INVERT ? step_dn : step_up;
        dn_i = STEP_INVERT ? step_up : step_dn;
        en_q_next = DRIVE_EN;
        pos_next = pos_reg;
        anchor_next = anchor_reg;
        base_next = base_reg;
        if (CTRL_MODE == SCID_POS && CMD_SRC == SCID_SRC_STEP) begin
            if (up_i) begin
                pos_next = pos_reg + 32'({16'h0000, GEAR_RATIO});
            end else if (dn_i) begin
                pos_next = pos_reg - 32'({16'h0000, GEAR_RATIO});
            end
        end else if (CTRL_MODE == SCID_POS && CMD_SRC == SCID_SRC_ANA) begin
            if (DRIVE_EN && !en_q_reg) begin
                base_next = ana_mon_reg;
                anchor_next = pos_reg;
            end else if (DRIVE_EN) begin
                // Relative move: scaled change since the enable snapshot
                pos_next = anchor_reg + scale_val(17'(ana_mon_reg) - 17'(base_reg), ANA_SCALE);
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cur_reg <= 16'sh0000;
            vel_reg <= 16'sh0000;
            pos_reg <= 32'sh00000000;
            anchor_reg <= 32'sh00000000;
            base_reg <= 16'sh0000;
            en_q_reg <= 1'b0;
            bypass_reg <= 1'b0;
            inhibit_reg <= 1'b0;
        end else begin
            cur_reg <= cur_next;
            vel_reg <= vel_next;
            pos_reg <= pos_next;
            anchor_reg <= anchor_next;
            base_reg <= base_next;
            en_q_reg <= en_q_next;
            bypass_reg <= bypass_next;
            inhibit_reg <= inhibit_next;
        end
    end

    // Measure: ten samples, one per gap, averaged
    scid_meas_st_t ms_st_reg, ms_st_next;
    logic [19:0] gap_reg, gap_next;
    logic [3:0] ms_n_reg, ms_n_next;
    logic signed [19:0] sum_reg, sum_next, sum_add;
    logic signed [15:0] avg_reg, avg_next;
    logic done_reg, done_next;

    always_comb begin
        ms_st_next = ms_st_reg;
        gap_next = gap_reg;
        ms_n_next = ms_n_reg;
        sum_next = sum_reg;
        avg_next = avg_reg;
        done_next = 1'b0;
        sum_add = sum_reg + 20'(ana_last_reg);
        case (ms_st_reg)
            SCID_MS_IDLE: begin
                if (MEAS_START) begin
                    gap_next = 20'h00000;
                    ms_n_next = 4'h0;
                    sum_next = 20'sh00000;
                    ms_st_next = SCID_MS_RUN;
                end
            end
            SCID_MS_RUN: begin
                if (gap_reg == 20'h00000) begin
                    sum_next = sum_add;
                    ms_n_next = ms_n_reg + 4'h1;
                    gap_next = 20'(MEAS_GAP_CYC - 1);
                    if (ms_n_reg == `SCID_MEAS_LAST) begin
                        avg_next = 16'(sum_add / 20'sd10);
                        done_next = 1'b1;
                        ms_st_next = SCID_MS_IDLE;
                    end
                end else begin
                    gap_next = gap_reg - 20'h00001;
                end
            end
            default: ms_st_next = SCID_MS_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ms_st_reg <= SCID_MS_IDLE;
            gap_reg <= 20'h00000;
            ms_n_reg <= 4'h0;
            sum_reg <= 20'sh00000;
            avg_reg <= 16'sh0000;
            done_reg <= 1'b0;
        end else begin
            ms_st_reg <= ms_st_next;
            gap_reg <= gap_next;
            ms_n_reg <= ms_n_next;
            sum_reg <= sum_next;
            avg_reg <= avg_next;
            done_reg <= done_next;
        end
    end

    assign CUR_CMD = cur_reg;
    assign VEL_CMD = vel_reg;
    assign POS_CMD = pos_reg;
    assign ANA_MON = ana_mon_reg;
    assign MEAS_AVG = avg_reg;
    assign MEAS_BUSY = ms_st_reg[1];
    assign MEAS_DONE = done_reg;
    assign TRAJ_BYPASS = bypass_reg;
    assign MOTION_INHIBIT = inhibit_reg;

    default clocking dcb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);

    logic pwm_cur, pwm_clean;
    assign pwm_cur = CTRL_MODE == SCID_CUR && CMD_SRC == SCID_SRC_PWM;
    assign pwm_clean = !stuck_hi && !stuck_lo;

    sequence s_meas_start;
        ms_st_reg == SCID_MS_IDLE && MEAS_START;
    endsequence
    sequence s_en_rise;
        CTRL_MODE == SCID_POS && CMD_SRC == SCID_SRC_ANA && DRIVE_EN && !en_q_reg;
    endsequence

    AST_ONE_WIRE_HALF: assert property (
        pwm_cur && !PWM_TWO_WIRE && pwm_clean && duty == `SCID_DUTY_HALF |=> CUR_CMD == 16'sh0000)
        else $error("Half duty did not give zero");
    // Measured duty never reaches full; a line held high stands for it
    AST_TWO_WIRE_FULL: assert property (
        pwm_cur && PWM_TWO_WIRE && !PWM_INVERT && !PWM_STUCK_PROT && stuck_hi && !sync2_reg[1]
        |=> CUR_CMD == 16'sh7FFF)
        else $error("Full duty did not give maximum");
    AST_STUCK_ZERO: assert property (
        pwm_cur && PWM_STUCK_PROT && (stuck_hi || stuck_lo) |=> CUR_CMD == 16'sh0000)
        else $error("Stuck input not zeroed");
    AST_VEL_ONLY: assert property (
        CTRL_MODE != SCID_VEL |=> VEL_CMD == 16'sh0000)
        else $error("Velocity command outside velocity mode");
    AST_GEAR_STEP: assert property (
        CTRL_MODE == SCID_POS && CMD_SRC == SCID_SRC_STEP && step_up && !STEP_INVERT
        |=> POS_CMD == $past(POS_CMD) + 32'({16'h0000, $past(GEAR_RATIO)}))
        else $error("Step not geared");
    AST_BYPASS: assert property (
        ACCEL_LIMIT == 16'h0000 && CMD_SRC == SCID_SRC_STEP |=> TRAJ_BYPASS && !MOTION_INHIBIT)
        else $error("Smoothing not bypassed");
    AST_INHIBIT: assert property (
        ACCEL_LIMIT == 16'h0000 && CMD_SRC == SCID_SRC_NET |=> MOTION_INHIBIT && !TRAJ_BYPASS)
        else $error("Motion not inhibited");
    AST_DB_ZERO: assert property (
        ANA_VALID && ana_mag <= 32'({16'h0000, ANA_DEADBAND}) |=> ANA_MON == 16'sh0000)
        else $error("Dead band sample not zero");
    AST_MEAS_RUN: assert property (
        s_meas_start |=> MEAS_BUSY ##1 (ms_n_reg == 4'h1))
        else $error("Measure did not take first sample");
    AST_MEAS_TEN: assert property (
        $rose(MEAS_DONE) |-> $past(ms_n_reg) == `SCID_MEAS_LAST)
        else $error("Measure did not average ten samples");
    AST_ANA_LATCH: assert property (
        s_en_rise |=> POS_CMD == $past(POS_CMD) && base_reg == $past(ana_mon_reg))
        else $error("Enable snapshot not taken");
endmodule // scid_top

// File: pkg/scid_map.svh
// Timing counts, fixed points and limits of the servo command input decoder
`ifndef SCID_MAP_SVH
`define SCID_MAP_SVH
`define SCID_CLK_HZ 20000000
`define SCID_MEAS_N 10
`define SCID_MEAS_MS 200
`define SCID_MEAS_GAP_CYC ((`SCID_CLK_HZ / 1000) * `SCID_MEAS_MS / `SCID_MEAS_N)
`define SCID_STUCK_US 1000
`define SCID_STUCK_CYC ((`SCID_CLK_HZ / 1000000) * `SCID_STUCK_US)
`define SCID_DUTY_FULL 17'h08000
`define SCID_DUTY_HALF 17'h04000
`define SCID_SCALE_FRAC 12
`define SCID_DIV_LAST 5'h1F
`define SCID_CMD_MAX 32'sh00007FFF
`define SCID_CMD_MIN 32'shFFFF8001
`define SCID_MEAS_LAST 4'h9
`endif

// File: pkg/scid_pkg.sv
// Types of the servo command input decoder
package scid_pkg;
    typedef enum logic [2:0] {SCID_CUR = 3'b001, SCID_VEL = 3'b010, SCID_POS = 3'b100} scid_mode_t;
    typedef enum logic [1:0] {SCID_FMT_PD = 2'h0, SCID_FMT_UD = 2'h1, SCID_FMT_QUAD = 2'h2} scid_fmt_t;
    typedef enum logic [2:0] {
        SCID_SRC_ANA = 3'h0,
        SCID_SRC_PWM = 3'h1,
        SCID_SRC_STEP = 3'h2,
        SCID_SRC_NET = 3'h3,
        SCID_SRC_SER = 3'h4,
        SCID_SRC_PROG = 3'h5
    } scid_src_t;
    typedef enum logic [1:0] {SCID_DV_IDLE = 2'b01, SCID_DV_RUN = 2'b10} scid_div_st_t;
    typedef enum logic [1:0] {SCID_MS_IDLE = 2'b01, SCID_MS_RUN = 2'b10} scid_meas_st_t;
endpackage

// File: hw/scid_pwm_meas.sv
// PWM input duty measurement with serial divider and stuck-level detection
`timescale 1ns/1ps
`include "scid_map.svh"
module scid_pwm_meas
    import scid_pkg::*;
#(
    parameter int STUCK_CYC = `SCID_STUCK_CYC
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic pin,
    output logic [16:0] duty,
    output logic duty_vld,
    output logic stuck_hi,
    output logic stuck_lo
);
    logic pin_q_reg, pin_q_next;
    logic [15:0] hi_cnt_reg, hi_cnt_next, per_cnt_reg, per_cnt_next, hi_lat_reg, hi_lat_next;
    logic [15:0] den_reg, den_next;
    logic [19:0] idle_reg, idle_next;
    logic [31:0] num_reg, num_next, quo_reg, quo_next;
    logic [16:0] rem_reg, rem_next, rem_sh;
    logic [4:0] step_reg, step_next;
    logic [16:0] duty_reg, duty_next;
    logic vld_reg, vld_next;
    scid_div_st_t st_reg, st_next;
    logic rise, fall, stuck;

    always_comb begin
        rise = pin & ~pin_q_reg;
        fall = ~pin & pin_q_reg;
        stuck = idle_reg >= 20'(STUCK_CYC);
        pin_q_next = pin;
        hi_cnt_next = rise ? 16'h0001 : ((pin && hi_cnt_reg != 16'hFFFF) ? hi_cnt_reg + 16'h0001 : hi_cnt_reg);
        per_cnt_next = rise ? 16'h0001 : ((per_cnt_reg != 16'hFFFF) ? per_cnt_reg + 16'h0001 : per_cnt_reg);
        hi_lat_next = fall ? hi_cnt_reg : hi_lat_reg;
        idle_next = (rise | fall) ? 20'h00000 : (stuck ? idle_reg : idle_reg + 20'h00001);
        st_next = st_reg;
        num_next = num_reg;
        den_next = den_reg;
        rem_next = rem_reg;
        quo_next = quo_reg;
        step_next = step_reg;
        duty_next = duty_reg;
        vld_next = 1'b0;
        rem_sh = {rem_reg[15:0], num_reg[31]};
        case (st_reg)
            SCID_DV_IDLE: begin
                // Duty of the period just closed, as high time over period in Q15
                if (rise && !stuck && per_cnt_reg != 16'h0000) begin
                    num_next = {1'b0, hi_lat_reg, 15'h0000};
                    den_next = per_cnt_reg;
                    rem_next = 17'h00000;
                    quo_next = 32'h00000000;
                    step_next = 5'h00;
                    st_next = SCID_DV_RUN;
                end
            end
            SCID_DV_RUN: begin
                num_next = {num_reg[30:0], 1'b0};
                if (rem_sh >= {1'b0, den_reg}) begin
                    rem_next = rem_sh - {1'b0, den_reg};
                    quo_next = {quo_reg[30:0], 1'b1};
                end else begin
                    rem_next = rem_sh;
                    quo_next = {quo_reg[30:0], 1'b0};
                end
                step_next = step_reg + 5'h01;
                if (step_reg == `SCID_DIV_LAST) begin
                    duty_next = quo_next[16:0];
                    vld_next = 1'b1;
                    st_next = SCID_DV_IDLE;
                end
            end
            default: st_next = SCID_DV_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_q_reg <= 1'b0;
            hi_cnt_reg <= 16'h0000;
            per_cnt_reg <= 16'h0000;
            hi_lat_reg <= 16'h0000;
            idle_reg <= 20'h00000;
            st_reg <= SCID_DV_IDLE;
            num_reg <= 32'h00000000;
            den_reg <= 16'h0000;
            rem_reg <= 17'h00000;
            quo_reg <= 32'h00000000;
            step_reg <= 5'h00;
            duty_reg <= `SCID_DUTY_HALF;
            vld_reg <= 1'b0;
        end else begin
            pin_q_reg <= pin_q_next;
            hi_cnt_reg <= hi_cnt_next;
            per_cnt_reg <= per_cnt_next;
            hi_lat_reg <= hi_lat_next;
            idle_reg <= idle_next;
            st_reg <= st_next;
            num_reg <= num_next;
            den_reg <= den_next;
            rem_reg <= rem_next;
            quo_reg <= quo_next;
            step_reg <= step_next;
            duty_reg <= duty_next;
            vld_reg <= vld_next;
        end
    end

    assign duty = duty_reg;
    assign duty_vld = vld_reg;
    assign stuck_hi = stuck & pin_q_reg;
    assign stuck_lo = stuck & ~pin_q_reg;
endmodule // scid_pwm_meas

// File: hw/scid_step_dec.sv
// Step input decoder for pulse/direction, up/down and quadrature formats
`timescale 1ns/1ps
module scid_step_dec
    import scid_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic a,
    input wire logic b,
    input scid_fmt_t fmt,
    input wire logic fall_sel,
    output logic up,
    output logic dn
);
    logic a_q_reg, a_q_next, b_q_reg, b_q_next;
    logic ea, eb, ca, cb;

    always_comb begin
        a_q_next = a;
        b_q_next = b;
        ca = a ^ a_q_reg;
        cb = b ^ b_q_reg;
        ea = fall_sel ? (a_q_reg & ~a) : (a & ~a_q_reg);
        eb = fall_sel ? (b_q_reg & ~b) : (b & ~b_q_reg);
        up = 1'b0;
        dn = 1'b0;
        case (fmt)
            SCID_FMT_PD: begin
                up = ea & b;
                dn = ea & ~b;
            end
            SCID_FMT_UD: begin
                // Coincident up and down pulses cancel
                up = ea & ~eb;
                dn = eb & ~ea;
            end
            SCID_FMT_QUAD: begin
                up = (ca ^ cb) & (a ^ b_q_reg);
                dn = (ca ^ cb) & ~(a ^ b_q_reg);
            end
            default: begin
                up = 1'b0;
                dn = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            a_q_reg <= 1'b0;
            b_q_reg <= 1'b0;
        end else begin
            a_q_reg <= a_q_next;
            b_q_reg <= b_q_next;
        end
    end

    AST_QUAD_BOTH: assert property (@(posedge clk) disable iff (!arst_n)
        (fmt == SCID_FMT_QUAD && ca && cb) |-> (!up && !dn))
        else $error("Quadrature double change counted");
    AST_QUAD_DIR: assert property (@(posedge clk) disable iff (!arst_n)
        (fmt == SCID_FMT_QUAD && !a_q_reg && !b_q_reg && a && !b) |-> up)
        else $error("Quadrature A-leads-B not counted up");
endmodule // scid_step_dec

// File: verif/scid_host.sv
// Motion controller model driving the step and PWM pins
`timescale 1ns/1ps
module scid_host (
    input wire logic clk,
    output logic pa,
    output logic pb,
    output logic pw,
    output logic pd
);
    initial begin
        {pa, pb, pw, pd} = 4'h0;
    end
    // Rest long enough for sync and decode
    task automatic step(input logic [1:0] ab);
        @(posedge clk);
        {pa, pb} <= ab;
        repeat (6) @(posedge clk);
    endtask
    // Level held with no edges, polarity positive
    task automatic hold(input logic lvl, input int n);
        @(posedge clk);
        pw <= lvl;
        pd <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    // Fixed 100-cycle period, polarity level held static
    task automatic pwm(input int hi, input int n, input logic pol);
        repeat (n) begin
            @(posedge clk);
            pd <= pol;
            pw <= 1'b1;
            repeat (hi) @(posedge clk);
            pw <= 1'b0;
            repeat (99 - hi) @(posedge clk);
        end
    endtask
endmodule // scid_host

// File: verif/testbench.sv
// Self-checking bench of the servo command input decoder
`timescale 1ns/1ps
module testbench;
    import scid_pkg::*;
    logic clk, rst_n, tw, inv, sinv, fall, vld, start, busy, done, byp, inh, pa, pb, pw, pd, prot, en;
    scid_mode_t mode;
    scid_src_t src;
    scid_fmt_t fmt;
    logic [15:0] gear, acc, band, scale;
    logic signed [15:0] samp, offs, cur, vel, mon, avg;
    logic signed [31:0] pos, ep;
    int mismatches, comparisons, i;
    scid_host u_host (.clk(clk), .pa(pa), .pb(pb), .pw(pw), .pd(pd));
    scid_top #(.MEAS_GAP_CYC(20), .STUCK_CYC(200)) u_dut (
        .CORE_CLK(clk), .ARST_N(rst_n), .PWM_IN_PIN(pw), .PWM_DIR_PIN(pd), .STEP_A_PIN(pa),
        .STEP_B_PIN(pb), .CTRL_MODE(mode), .CMD_SRC(src), .PWM_TWO_WIRE(tw), .PWM_INVERT(inv),
        .PWM_STUCK_PROT(prot), .STEP_FMT(fmt), .STEP_FALL_EDGE(fall), .STEP_INVERT(sinv),
        .GEAR_RATIO(gear), .ACCEL_LIMIT(acc), .DRIVE_EN(en), .ANA_SAMPLE(samp), .ANA_VALID(vld),
        .ANA_OFFSET(offs), .ANA_DEADBAND(band), .ANA_SCALE(scale), .MEAS_START(start),
        .CUR_CMD(cur), .VEL_CMD(vel), .POS_CMD(pos), .ANA_MON(mon), .MEAS_AVG(avg),
        .MEAS_BUSY(busy), .MEAS_DONE(done), .TRAJ_BYPASS(byp), .MOTION_INHIBIT(inh));
    task automatic test_done();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask
    // Deltas are 2-bit signed steps, scaled by gear 3
    task automatic seq(input scid_fmt_t f, input logic fl, input logic iv, input logic [7:0] ab, input logic [7:0] d);
        @(posedge clk);
        fmt <= f;
        fall <= fl;
        sinv <= iv;
        for (int k = 0; k < 4; k++) begin
            u_host.step(ab[7 - 2 * k -: 2]);
            ep = ep + $signed(d[7 - 2 * k -: 2]) * 3;
            #1;
            chk(pos, ep);
        end
    endtask
    task automatic ana(input logic signed [15:0] s, input logic signed [15:0] m, input logic signed [15:0] c);
        @(posedge clk);
        samp <= s;
        vld <= 1'b1;
        @(posedge clk);
        vld <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(mon, m);
        chk(cur, c);
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        {rst_n, tw, inv, sinv, fall, vld, start, prot, en} = 9'h000;
        mode = SCID_CUR;
        src = SCID_SRC_ANA;
        fmt = SCID_FMT_PD;
        {gear, acc, band, scale, samp, offs, ep} = '0;
        mismatches = 0;
        comparisons = 0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        mode <= SCID_POS;
        src <= SCID_SRC_STEP;
        gear <= 16'h0003;
        acc <= 16'h0001;
        seq(SCID_FMT_PD, 1'b0, 1'b0, 8'h77, 8'h11);
        seq(SCID_FMT_PD, 1'b1, 1'b1, 8'h88, 8'h11);
        seq(SCID_FMT_UD, 1'b0, 1'b0, 8'h84, 8'h4C);
        seq(SCID_FMT_QUAD, 1'b0, 1'b0, 8'hD2, 8'h15);
        seq(SCID_FMT_QUAD, 1'b0, 1'b1, 8'h1E, 8'h55);
        mode <= SCID_CUR;
        src <= SCID_SRC_ANA;
        offs <= 16'shFF9C;
        band <= 16'h0032;
        scale <= 16'h2000;
        ana(16'sh012C, 16'sh0096, 16'sh012C);
        ana(16'sh0078, 16'sh0000, 16'sh0000);
        ana(16'shFE70, 16'shFE3E, 16'shFC7C);
        @(posedge clk);
        samp <= 16'sh03E8;
        vld <= 1'b1;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        for (i = 0; i < 400 && done !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        if (i == 400) begin
            mismatches++;
            test_done();
        end
        chk(avg, 16'sh03E8);
        @(posedge clk);
        vld <= 1'b0;
        src <= SCID_SRC_PWM;
        u_host.pwm(75, 4, 1'b0);
        #1;
        chk(cur, 16'sh4000);
        @(posedge clk);
        inv <= 1'b1;
        u_host.pwm(75, 3, 1'b0);
        #1;
        chk(cur, 16'shC000);
        @(posedge clk);
        mode <= SCID_VEL;
        tw <= 1'b1;
        inv <= 1'b0;
        u_host.pwm(25, 3, 1'b1);
        #1;
        chk(vel, 16'shE000);
        @(posedge clk);
        mode <= SCID_CUR;
        u_host.hold(1'b1, 300);
        #1;
        chk(cur, 16'sh7FFF);
        @(posedge clk);
        tw <= 1'b0;
        prot <= 1'b1;
        u_host.hold(1'b0, 260);
        #1;
        chk(cur, 16'sh0000);
        @(posedge clk);
        mode <= SCID_POS;
        src <= SCID_SRC_ANA;
        en <= 1'b1;
        ana(16'sh044C, 16'sh03B6, 16'sh0000);
        chk(pos, ep + 32'sh000000C8);
        @(posedge clk);
        acc <= 16'h0000;
        src <= SCID_SRC_NET;
        repeat (3) @(posedge clk);
        #1;
        chk({byp, inh}, 2'b01);
        @(posedge clk);
        src <= SCID_SRC_STEP;
        repeat (3) @(posedge clk);
        #1;
        chk({byp, inh}, 2'b10);
        test_done();
    end
endmodule // testbench
